// ---- pft_cli.sv ----
// client end: frame submission, time-of-day source, result and rx filtering
`timescale 1ns/1ps
`default_nettype none
module pft_cli (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    pft_if.cli lnk,
    input wire logic send_i,
    input wire logic [pft_pkg::OP_W-1:0] send_op_i,
    input wire logic [pft_pkg::TAG_W-1:0] send_tag_i,
    input wire logic [pft_pkg::TRIM_W-1:0] trim_i,
    input wire logic [pft_pkg::ETYPE_W-1:0] rx_etype_i,
    output logic res_valid_o,
    output logic [pft_pkg::TAG_W-1:0] res_tag_o,
    output logic [pft_pkg::TIME_W-1:0] res_ts_o,
    output logic keep_valid_o,
    output logic [pft_pkg::TIME_W-1:0] keep_ts_o,
    output logic fault_o
);
    import pft_pkg::*;

    logic tx_sop_q;
    logic [OP_W-1:0] op_q;
    logic [TAG_W-1:0] tag_q;
    logic [TRIM_W-1:0] trim_q;
    logic [TIME_W-1:0] tod_q;
    logic res_valid_q;
    logic [TAG_W-1:0] res_tag_q;
    logic [TIME_W-1:0] res_ts_q;
    logic keep_valid_q;
    logic [TIME_W-1:0] keep_ts_q;

    // ****************************************************************
    // time of day, one copy feeds both directions
    // ****************************************************************
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            tod_q <= '0;
        end else begin
            tod_q <= pft_add_ns(tod_q, NS_STEP); // [R16] [R12] [R14]
        end
    end
    assign lnk.tx_time = tod_q;
    assign lnk.rx_time = tod_q; // [R6]

    // ****************************************************************
    // frame submission
    // ****************************************************************
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            tx_sop_q <= 1'b0;
            op_q <= OP_NONE;
            tag_q <= '0;
            trim_q <= '0;
        end else begin
            tx_sop_q <= send_i;
            op_q <= send_op_i; // [R15]
            // tag rides with the first cycle only
            tag_q <= send_i ? send_tag_i : '0; // [R1]
            trim_q <= trim_i;
        end
    end
    assign lnk.tx_sop = tx_sop_q;
    assign lnk.frame_time_op_code = op_q;
    assign lnk.tx_tag = tag_q;
    assign lnk.trim = trim_q;

    // ****************************************************************
    // results
    // ****************************************************************
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            res_valid_q <= 1'b0;
            res_tag_q <= '0;
            res_ts_q <= '0;
            keep_valid_q <= 1'b0;
            keep_ts_q <= '0;
        end else begin
            res_valid_q <= lnk.ts_valid;
            if (lnk.ts_valid) begin
                res_tag_q <= lnk.ts_tag;
                res_ts_q <= lnk.ts_value;
            end
            // every rx frame is stamped; only time frames keep theirs
            keep_valid_q <= lnk.rx_sop && (rx_etype_i == ETYPE_TIME); // [R9]
            if (lnk.rx_sop && (rx_etype_i == ETYPE_TIME)) begin
                keep_ts_q <= lnk.rx_ts;
            end
        end
    end
    assign res_valid_o = res_valid_q;
    assign res_tag_o = res_tag_q;
    assign res_ts_o = res_ts_q;
    assign keep_valid_o = keep_valid_q;
    assign keep_ts_o = keep_ts_q;
    assign fault_o = lnk.wr_err | lnk.rd_err;

endmodule : pft_cli
`default_nettype wire

// ---- pft_dev.sv ----
// device end: tx capture with tag queue and trim, rx stamp on every frame
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// (R1) client gives tag on first cycle; no-op ignores
// (R2) tag returned with captured timestamp on result
// (R3) one-step stamp shifted by 11-bit trim
// (R4) tag write fault sticky until reset
// (R5) tag read fault sticky until reset
// (R6) rx time shares tx format and clock
// (R7) rx timestamp valid on packet's first cycle
// (R8) stamp every rx frame, no type check
// (R9) client filters rx stamps by ethertype
// (R10) stamp tx only when marked, pair tag
// (R11) sample time when start passes capture plane
// (R12) time source arrives already in our clock
// (R13) correction arithmetic assumes fixed transceiver rate
// (R14) integrator fixes clock rates at build
// (R15) op 00 none, 01 one-step, 10 two-step, 11 none
// (R16) ns in low 32, seconds in high 48
// (R17) valid strobe with each result and tag
// (R18) tags queued first-in first-out
module pft_dev #(
    parameter int CAP_DLY = pft_pkg::CAP_DLY_DEF,
    parameter int TAG_DEPTH = pft_pkg::TAG_DEPTH_DEF
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    pft_if.dev lnk,
    input wire logic line_rx_sop_i,
    output logic line_tx_cap_o
);
    import pft_pkg::*;

    // pointers wrap at any depth, not only at powers of two
    localparam int PTR_W = (TAG_DEPTH > 1) ? $clog2(TAG_DEPTH) : 1;
    localparam int CNT_W = $clog2(TAG_DEPTH + 1);
    localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(TAG_DEPTH - 1);
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(TAG_DEPTH);

    logic [CAP_DLY-1:0] sop_pipe_q;
    logic [OP_W-1:0] op_pipe_q [CAP_DLY];
    logic [TAG_W-1:0] tag_mem_q [TAG_DEPTH];
    logic [PTR_W-1:0] wr_ptr_q;
    logic [PTR_W-1:0] rd_ptr_q;
    logic [CNT_W-1:0] cnt_q;
    logic cap_sop;
    logic [OP_W-1:0] cap_op;
    logic push;
    logic pop;
    logic full;
    logic empty;
    logic push_ok;
    logic pop_ok;
    logic [NS_W-1:0] trim_ns;
    logic ts_valid_q;
    logic [TAG_W-1:0] ts_tag_q;
    logic [TIME_W-1:0] ts_value_q;
    logic os_valid_q;
    logic [TIME_W-1:0] os_value_q;
    logic wr_err_q;
    logic rd_err_q;
    logic rx_sop_q;
    logic [TIME_W-1:0] rx_ts_q;

    function automatic logic [PTR_W-1:0] ptr_next(input logic [PTR_W-1:0] p);
        return (p == PTR_LAST) ? '0 : p + PTR_W'(1);
    endfunction : ptr_next

    // ****************************************************************
    // transmit path to the capture plane
    // ****************************************************************
    // fixed pipeline stands in for the mac/pcs latency ahead of the plane
    // unmarked frames travel too, so the capture pulse shows every start
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            sop_pipe_q <= '0;
            for (int i = 0; i < CAP_DLY; i++) begin
                op_pipe_q[i] <= OP_NONE;
            end
        end else begin
            sop_pipe_q[0] <= lnk.tx_sop;
            op_pipe_q[0] <= lnk.tx_sop ? lnk.frame_time_op_code : OP_NONE;
            for (int i = 1; i < CAP_DLY; i++) begin
                sop_pipe_q[i] <= sop_pipe_q[i-1];
                op_pipe_q[i] <= op_pipe_q[i-1];
            end
        end
    end
    assign cap_sop = sop_pipe_q[CAP_DLY-1];
    assign cap_op = op_pipe_q[CAP_DLY-1];
    assign line_tx_cap_o = cap_sop;

    // ****************************************************************
    // tag queue
    // ****************************************************************
    // a push into a full queue is refused even if a pop frees a slot
    // in that cycle; with CAP_DLY < TAG_DEPTH this never arises
    assign push = lnk.tx_sop && pft_wants_ts(lnk.frame_time_op_code); // [R1] [R15]
    assign pop = cap_sop && pft_wants_ts(cap_op); // [R10]
    assign full = (cnt_q == CNT_FULL);
    assign empty = (cnt_q == '0);
    assign push_ok = push && !full;
    assign pop_ok = pop && !empty;

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push_ok) begin
                wr_ptr_q <= ptr_next(wr_ptr_q); // [R18]
            end
            if (pop_ok) begin
                rd_ptr_q <= ptr_next(rd_ptr_q); // [R18]
            end
            if (push_ok && !pop_ok) begin
                cnt_q <= cnt_q + CNT_W'(1);
            end else if (pop_ok && !push_ok) begin
                cnt_q <= cnt_q - CNT_W'(1);
            end
        end
    end

    // storage needs no reset; contents only read behind a count
    always_ff @(posedge clk_sys_i) begin
        if (push_ok) begin
            tag_mem_q[wr_ptr_q] <= lnk.tx_tag;
        end
    end

    // a refused push leaves the queue one tag short; the capture that
    // later finds it empty raises the read fault
    // faults stay up until the path is reset; nothing else clears them
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            wr_err_q <= 1'b0;
            rd_err_q <= 1'b0;
        end else begin
            if (push && full) begin
                wr_err_q <= 1'b1; // [R4]
            end
            if (pop && empty) begin
                rd_err_q <= 1'b1; // [R5]
            end
        end
    end

    // ****************************************************************
    // capture and results
    // ****************************************************************
    // fractional eighths round to the nearest whole ns in ordinary mode
    // no rate input: clock rates are fixed when the core is built
    assign trim_ns = NS_W'(lnk.trim[TRIM_NS_MSB:TRIM_NS_LSB])
                   + NS_W'(lnk.trim[TRIM_FRAC_MSB:0] >= TRIM_FRAC_HALF); // [R3] [R13]

    // ts_* also report one-step frames; os_* is the extra one-step view
    // os_value carries into seconds when the trim crosses a second
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            ts_valid_q <= 1'b0;
            ts_tag_q <= '0;
            ts_value_q <= '0;
            os_valid_q <= 1'b0;
            os_value_q <= '0;
        end else begin
            ts_valid_q <= pop_ok; // [R17] [R10]
            os_valid_q <= pop_ok && (cap_op == OP_ONE_STEP);
            if (pop_ok) begin
                ts_tag_q <= tag_mem_q[rd_ptr_q]; // [R2]
                ts_value_q <= lnk.tx_time; // [R11] [R16]
                os_value_q <= pft_add_ns(lnk.tx_time, trim_ns); // [R3]
            end
        end
    end

    // ****************************************************************
    // receive: stamp every frame, present with the delayed start
    // ****************************************************************
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            rx_sop_q <= 1'b0;
            rx_ts_q <= '0;
        end else begin
            // one stage, so rx_sop and rx_ts leave together
            rx_sop_q <= line_rx_sop_i; // [R7]
            if (line_rx_sop_i) begin
                rx_ts_q <= lnk.rx_time; // [R8] [R11]
            end
        end
    end

    // ****************************************************************
    // link outputs, all straight from registers
    // ****************************************************************
    assign lnk.ts_valid = ts_valid_q;
    assign lnk.ts_tag = ts_tag_q;
    assign lnk.ts_value = ts_value_q;
    assign lnk.os_valid = os_valid_q;
    assign lnk.os_value = os_value_q;
    assign lnk.wr_err = wr_err_q;
    assign lnk.rd_err = rd_err_q;
    assign lnk.rx_sop = rx_sop_q;
    assign lnk.rx_ts = rx_ts_q;

endmodule : pft_dev
`default_nettype wire

// ---- pft_if.sv ----
// link between the timestamp unit and its client / time source
`timescale 1ns/1ps
`default_nettype none
interface pft_if;
    import pft_pkg::*;
    logic tx_sop;
    logic [OP_W-1:0] frame_time_op_code;
    logic [TAG_W-1:0] tx_tag;
    logic [TRIM_W-1:0] trim;
    logic [TIME_W-1:0] tx_time;
    logic [TIME_W-1:0] rx_time;
    logic ts_valid;
    logic [TAG_W-1:0] ts_tag;
    logic [TIME_W-1:0] ts_value;
    logic os_valid;
    logic [TIME_W-1:0] os_value;
    logic wr_err;
    logic rd_err;
    logic rx_sop;
    logic [TIME_W-1:0] rx_ts;

    modport dev (
        input tx_sop, frame_time_op_code, tx_tag, trim, tx_time, rx_time,
        output ts_valid, ts_tag, ts_value, os_valid, os_value, wr_err, rd_err,
        output rx_sop, rx_ts
    );
    modport cli (
        output tx_sop, frame_time_op_code, tx_tag, trim, tx_time, rx_time,
        input ts_valid, ts_tag, ts_value, os_valid, os_value, wr_err, rd_err,
        input rx_sop, rx_ts
    );
endinterface : pft_if
`default_nettype wire

// ---- pft_pkg.sv ----
// shared constants, op codes and time helpers for the frame timestamp unit
package pft_pkg;

    // ****************************************************************
    // widths
    // ****************************************************************
    localparam int TIME_W = 80;
    localparam int TAG_W = 16;
    localparam int TRIM_W = 11;
    localparam int NS_W = 32;
    localparam int SEC_W = 48;
    localparam int OP_W = 2;
    localparam int ETYPE_W = 16;

    // ****************************************************************
    // per-frame operation codes
    // ****************************************************************
    localparam logic [1:0] OP_NONE = 2'h0;
    localparam logic [1:0] OP_ONE_STEP = 2'h1;
    localparam logic [1:0] OP_TWO_STEP = 2'h2;
    localparam logic [1:0] OP_RESERVED = 2'h3;

    // ****************************************************************
    // trim field layout: whole ns above, eighths of a ns below
    // ****************************************************************
    localparam int TRIM_NS_LSB = 3;
    localparam int TRIM_NS_MSB = 10;
    localparam int TRIM_FRAC_MSB = 2;
    localparam logic [2:0] TRIM_FRAC_HALF = 3'h4;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam logic [NS_W-1:0] NS_PER_SEC = 32'h3B9ACA00;
    localparam int CLK_FREQ_MHZ = 200;
    localparam logic [NS_W-1:0] NS_STEP = NS_W'(1000 / CLK_FREQ_MHZ);
    // transceiver rate the correction arithmetic is fixed for at 25G (kHz)
    localparam int XCVR_FREQ_KHZ = 390625;
    localparam int CAP_DLY_DEF = 4;
    localparam int TAG_DEPTH_DEF = 4;
    localparam logic [ETYPE_W-1:0] ETYPE_TIME = 16'h88F7;

    // ****************************************************************
    // helpers
    // ****************************************************************
    // reserved code falls through to no action
    function automatic logic pft_wants_ts(input logic [OP_W-1:0] op);
        return (op == OP_ONE_STEP) || (op == OP_TWO_STEP);
    endfunction : pft_wants_ts

    // add ns to an ordinary-mode time, carrying into seconds
    function automatic logic [TIME_W-1:0] pft_add_ns(input logic [TIME_W-1:0] t,
                                                      input logic [NS_W-1:0] d);
        logic [NS_W:0] sum;
        logic [SEC_W-1:0] sec;
        sum = {1'b0, t[NS_W-1:0]} + {1'b0, d};
        sec = t[TIME_W-1:NS_W];
        if (sum >= {1'b0, NS_PER_SEC}) begin
            sum = sum - {1'b0, NS_PER_SEC};
            sec = sec + SEC_W'(1);
        end
        return {sec, sum[NS_W-1:0]};
    endfunction : pft_add_ns

endpackage : pft_pkg

// ---- pft_properties.sv ----
// concurrent checks on the link between the two timestamp unit ends
`timescale 1ns/1ps
`default_nettype none
module pft_properties #(
    parameter int CAP_DLY = 4
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic tx_sop,
    input wire logic [pft_pkg::OP_W-1:0] frame_time_op_code,
    input wire logic [pft_pkg::TAG_W-1:0] tx_tag,
    input wire logic [pft_pkg::TRIM_W-1:0] trim,
    input wire logic [pft_pkg::TIME_W-1:0] tx_time,
    input wire logic [pft_pkg::TIME_W-1:0] rx_time,
    input wire logic ts_valid,
    input wire logic [pft_pkg::TAG_W-1:0] ts_tag,
    input wire logic [pft_pkg::TIME_W-1:0] ts_value,
    input wire logic os_valid,
    input wire logic [pft_pkg::TIME_W-1:0] os_value,
    input wire logic wr_err,
    input wire logic rd_err,
    input wire logic rx_sop,
    input wire logic [pft_pkg::TIME_W-1:0] rx_ts
);
    import pft_pkg::*;
    localparam int ANS_LAT = CAP_DLY + 1;
    logic marked;
    logic [NS_W-1:0] trim_ns;
    assign marked = tx_sop && (frame_time_op_code inside {OP_ONE_STEP, OP_TWO_STEP});
    // half a ns or more rounds up; no seconds carry, runs stay far below a second
    assign trim_ns = NS_W'(trim[10:3]) + NS_W'(trim[2:0] >= 3'h4);

    // ****************************************************************
    // properties
    // ****************************************************************
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);

    // marked frame whose tag found room in the queue
    sequence s_taken;
        marked ##1 !wr_err;
    endsequence

    a_tag_return: assert property (
        s_taken |-> ##CAP_DLY ts_valid && ts_tag == $past(tx_tag, ANS_LAT))
        else $error("tx result missing or carries the wrong tag");
    a_noop_ignored: assert property (
        tx_sop && !marked |-> ##ANS_LAT !ts_valid)
        else $error("tx result for a frame without timestamp request");
    a_one_step_kind: assert property (
        ts_valid || os_valid |-> ts_valid
            && os_valid == ($past(frame_time_op_code, ANS_LAT) == OP_ONE_STEP))
        else $error("one-step result flag does not match op code");
    a_tx_sample: assert property (
        ts_valid |-> ts_value == $past(tx_time))
        else $error("tx timestamp not the time at the capture edge");
    a_trim_shift: assert property (
        os_valid |-> os_value == {ts_value[TIME_W-1:NS_W], ts_value[NS_W-1:0] + $past(trim_ns)})
        else $error("one-step timestamp not shifted by trim");
    a_wr_sticky: assert property (
        wr_err |=> wr_err)
        else $error("write fault cleared without reset");
    a_rd_sticky: assert property (
        rd_err |=> rd_err)
        else $error("read fault cleared without reset");
    a_rx_stamp: assert property (
        rx_sop |-> rx_ts == $past(rx_time))
        else $error("rx timestamp not the time at the start edge");
    a_rx_hold: assert property (
        !rx_sop |-> $stable(rx_ts))
        else $error("rx timestamp changed between frames");
    a_ts_hold: assert property (
        !ts_valid |-> $stable(ts_value) && $stable(ts_tag))
        else $error("tx result changed without valid strobe");
endmodule : pft_properties
`default_nettype wire

// ---- ptp_frame_timestamp_unit_tb_top.sv ----
// self-checking bench joining device and client ends of the timestamp unit
`timescale 1ns/1ps
`default_nettype none
module ptp_frame_timestamp_unit_tb_top;
    import pft_pkg::*;
    // small queue so three back-to-back frames overflow it
    localparam int CAP = 4;
    localparam int DEPTH = 2;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic send_i = 1'b0;
    logic [OP_W-1:0] send_op_i = 2'h0;
    logic [TAG_W-1:0] send_tag_i = 16'h0000;
    logic [TRIM_W-1:0] trim_i = 11'h000;
    logic [ETYPE_W-1:0] rx_etype_i = 16'h0000;
    logic line_rx_sop_i = 1'b0;
    logic res_valid, keep_valid, fault;
    logic [TAG_W-1:0] res_tag;
    logic [TIME_W-1:0] res_ts;
    logic [TIME_W-1:0] keep_ts;
    logic tx_cap;
    int cap_n = 0;
    logic [TIME_W-1:0] kts_q[$];
    int error_cnt = 0;
    int n_tests = 0;
    int rx_n = 0;
    int keep_n = 0;
    logic [TAG_W-1:0] tags_q[$];
    logic [TIME_W-1:0] ts_q[$];
    logic [NS_W-1:0] os_q[$];
    logic [TRIM_W-1:0] trims[4] = '{11'h00B, 11'h00C, 11'h010, 11'h7FF};
    logic [NS_W-1:0] shifts[4] = '{32'h00000001, 32'h00000002, 32'h00000002, 32'h00000100};

    always #2.5 clk_sys_i = ~clk_sys_i;

    pft_if pft_if_i ();
    pft_dev #(.CAP_DLY(CAP), .TAG_DEPTH(DEPTH)) pft_dev_i (.clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i), .lnk(pft_if_i.dev), .line_rx_sop_i(line_rx_sop_i),
        .line_tx_cap_o(tx_cap));
    pft_cli pft_cli_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .lnk(pft_if_i.cli),
        .send_i(send_i), .send_op_i(send_op_i), .send_tag_i(send_tag_i), .trim_i(trim_i),
        .rx_etype_i(rx_etype_i), .res_valid_o(res_valid), .res_tag_o(res_tag),
        .res_ts_o(res_ts), .keep_valid_o(keep_valid), .keep_ts_o(keep_ts), .fault_o(fault));
    pft_properties #(.CAP_DLY(CAP)) pft_properties_i (.clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i), .tx_sop(pft_if_i.tx_sop), .tx_tag(pft_if_i.tx_tag),
        .frame_time_op_code(pft_if_i.frame_time_op_code), .trim(pft_if_i.trim),
        .tx_time(pft_if_i.tx_time), .rx_time(pft_if_i.rx_time),
        .ts_valid(pft_if_i.ts_valid), .ts_tag(pft_if_i.ts_tag), .ts_value(pft_if_i.ts_value),
        .os_valid(pft_if_i.os_valid), .os_value(pft_if_i.os_value), .wr_err(pft_if_i.wr_err),
        .rd_err(pft_if_i.rd_err), .rx_sop(pft_if_i.rx_sop), .rx_ts(pft_if_i.rx_ts));

    // ****************************************************************
    // monitor and helpers
    // ****************************************************************
    // sampled mid-cycle, where every one-cycle pulse has settled
    always @(negedge clk_sys_i) begin
        if (res_valid === 1'b1) begin
            tags_q.push_back(res_tag);
            ts_q.push_back(res_ts);
        end
        if (pft_if_i.os_valid === 1'b1) begin
            os_q.push_back(pft_if_i.os_value[NS_W-1:0] - pft_if_i.ts_value[NS_W-1:0]);
        end
        if (pft_if_i.rx_sop === 1'b1) rx_n++;
        if (keep_valid === 1'b1) begin
            keep_n++;
            kts_q.push_back(keep_ts);
        end
        if (tx_cap === 1'b1) cap_n++;
    end

    task automatic chk(input logic [TIME_W-1:0] got, input logic [TIME_W-1:0] exp,
                       input string what);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask : chk

    task automatic tx_frame(input logic [OP_W-1:0] op, input logic [TAG_W-1:0] tag);
        send_i = 1'b1;
        send_op_i = op;
        send_tag_i = tag;
        @(negedge clk_sys_i);
    endtask : tx_frame

    task automatic tx_idle(input int n);
        send_i = 1'b0;
        repeat (n) @(negedge clk_sys_i);
        tags_q.delete();
        ts_q.delete();
        os_q.delete();
    endtask : tx_idle

    task automatic rx_frame(input logic [ETYPE_W-1:0] etype);
        line_rx_sop_i = 1'b1;
        @(negedge clk_sys_i);
        line_rx_sop_i = 1'b0;
        rx_etype_i = etype;
        @(negedge clk_sys_i);
        rx_etype_i = 16'h0000;
        @(negedge clk_sys_i);
    endtask : rx_frame

    task automatic do_reset();
        rst_n_i = 1'b0;
        repeat (5) @(negedge clk_sys_i);
        rst_n_i = 1'b1;
    endtask : do_reset

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish

    // ****************************************************************
    // tests
    // ****************************************************************
    initial begin
        repeat (2000) @(posedge clk_sys_i);
        error_cnt++;
        $display("unexpected at %0t: watchdog expired", $time);
        tally_and_finish();
    end

    initial begin
        do_reset();
        for (int op = 0; op < 4; op++) begin
            tx_frame(op[1:0], {14'h2A5C, op[1:0]});
        end
        send_i = 1'b0;
        repeat (12) @(negedge clk_sys_i);
        chk(tags_q.size(), 2, "result count");
        chk(tags_q[0], {14'h2A5C, 2'h1}, "one-step tag");
        chk(tags_q[1], {14'h2A5C, 2'h2}, "two-step tag");
        chk(ts_q[1] - ts_q[0], TIME_W'(NS_STEP), "back-to-back stamp gap");
        chk(os_q.size(), 1, "one-step result count");
        chk(cap_n, 4, "capture pulses for every start");
        tx_idle(0);
        $display("test op codes done");
        for (int i = 0; i < 4; i++) begin
            trim_i = trims[i];
            tx_frame(OP_ONE_STEP, 16'h5A00 + 16'(i));
            tx_idle(10);
            trim_i = 11'h000;
        end
        $display("test trim done");
        for (int i = 0; i < 4; i++) begin
            trim_i = trims[i];
            tx_frame(OP_ONE_STEP, 16'h5A00 + 16'(i));
            send_i = 1'b0;
            repeat (10) @(negedge clk_sys_i);
            chk(os_q.size(), 1, "trimmed result count");
            chk(os_q[0], shifts[i], "trim shift");
            chk(tags_q[0], 16'h5A00 + 16'(i), "trimmed frame tag");
            tx_idle(0);
        end
        $display("test trim values done");
        rx_frame(ETYPE_TIME);
        rx_frame(16'h0800);
        rx_frame(ETYPE_TIME);
        chk(rx_n, 3, "rx stamp count");
        chk(keep_n, 2, "kept rx stamps");
        chk(kts_q[1] - kts_q[0], TIME_W'(6 * NS_STEP), "kept stamp gap");
        $display("test rx done");
        for (int i = 1; i < 4; i++) begin
            tx_frame(OP_TWO_STEP, 16'(i));
        end
        send_i = 1'b0;
        repeat (12) @(negedge clk_sys_i);
        chk(pft_if_i.wr_err, 1'b1, "write fault");
        chk(pft_if_i.rd_err, 1'b1, "read fault");
        chk(fault, 1'b1, "client fault");
        chk(tags_q.size(), 2, "results before overflow");
        chk(tags_q[1], 16'h0002, "order before overflow");
        do_reset();
        chk({pft_if_i.wr_err, pft_if_i.rd_err}, 2'h0, "faults after reset");
        tx_idle(0);
        tx_frame(OP_TWO_STEP, 16'h7777);
        send_i = 1'b0;
        repeat (10) @(negedge clk_sys_i);
        chk(tags_q[0], 16'h7777, "tag after reset");
        $display("test overflow done");
        tally_and_finish();
    end
endmodule : ptp_frame_timestamp_unit_tb_top
`default_nettype wire
